// file: include/modbus_mw_pkg.sv
// Constants, states and the frame check shared by both ends of the link.
// Assumes one 100 MHz clock for both ends and a byte-wide link.
package modbus_mw_pkg;
  localparam int CLK_MHZ = 100;
  localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
  localparam logic [7:0] FN_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_BAD_FN = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] EXC_BAD_DATA = 8'h03;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [4:0] MAX_REGS = 5'h10;
  localparam int HDR_BYTES = 7;
  localparam int BUF_DEPTH = 41;
  localparam logic [5:0] FRAME_OVERHEAD = 6'h09;
  localparam logic [5:0] MIN_FRAME = 6'h04;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] REG_GROUP_HI = 16'h0030;
  localparam logic [15:0] REG_GROUP_LO = 16'h0031;
  localparam logic [15:0] REG_INCMD_HI = 16'h007C;
  localparam logic [15:0] REG_INCMD_LO = 16'h007D;
  localparam logic [15:0] REG_OUTST_HI = 16'h007E;
  localparam logic [15:0] REG_OUTST_LO = 16'h007F;
  localparam logic [15:0] GROUP_RST = 16'hFFFF;
  localparam logic [15:0] INCMD_RST = 16'h0000;
  localparam logic [7:0] GROUP_MAX = 8'h1F;
  // Host register map, byte addresses on the Avalon side
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_START = 8'h04;
  localparam logic [7:0] HREG_COUNT = 8'h08;
  localparam logic [7:0] HREG_STATUS = 8'h0C;
  localparam logic [7:0] HREG_DATA = 8'h40;
  localparam int RESP_WAIT_NS = 10000;
  localparam logic [10:0] RESP_WAIT_CYC = 11'(RESP_WAIT_NS * CLK_MHZ / 1000);

  typedef enum logic [3:0] {
    S_RX = 4'h1, S_CHK = 4'h2, S_WR = 4'h4, S_TX = 4'h8
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h1, H_SEND = 3'h2, H_WAIT = 3'h4
  } host_state_t;

  // Reflected CRC-16 with polynomial A001, one byte at a time
  function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                             input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction
endpackage

// file: include/modbus_link_if.sv
// Byte link between the bus master end and the slave device end.
// Assumes both ends on the same clock; one byte per valid cycle.
`timescale 1ns/1ps
`default_nettype none
interface modbus_link_if;
  logic q_valid;
  logic [7:0] q_data;
  logic q_last;
  logic r_valid;
  logic [7:0] r_data;
  logic r_last;
  modport device (input q_valid, input q_data, input q_last,
                  output r_valid, output r_data, output r_last);
  modport host (output q_valid, output q_data, output q_last,
                input r_valid, input r_data, input r_last);
endinterface
`default_nettype wire

// file: design/modbus_slave_end.sv
// Slave end: write-multiple handling and operation-command registers.
// Assumes frames arrive one byte per cycle, last byte flagged.
//
// Contract
// - At most sixteen registers per write-multiple query.
// - Registers applied in ascending address order.
// - Bad values give exception, earlier writes kept.
// - Master writes both halves in one query.
// - Query layout, byte count twice register count.
// - CRC low byte first; bad CRC frame dropped.
// - Each datum is two 16-bit registers.
// - Even address upper half, odd address lower.
// - Operation commands stay volatile, never stored.
// - Group pair read/write; -1 off, 1..31 parent.
// - Group pair resets to all ones.
// - Queries to own group address accepted.
// - Master accesses group halves in one query.
// - Input command pair writable, drives driver inputs.
// - Output status pair read-only, mirrors driver.
// - Function code 10h selects write-multiple.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module modbus_slave_end (
  input wire logic core_clk_i,
  input wire logic rst_i,
  modbus_link_if.device link,
  input wire logic [7:0] slave_addr_i,
  input wire logic [31:0] drv_status_i,
  output logic [31:0] drv_cmd_o,
  output logic [31:0] group_addr_o,
  output logic [31:0] drv_status_o
);
  import modbus_mw_pkg::*;

  dev_state_t st_q, st_d;
  logic [7:0] buf_q [0:BUF_DEPTH-1];
  logic [5:0] len_q, len_d;
  logic ovf_q, ovf_d;
  logic [15:0] crc_q, crc_d;
  logic [4:0] idx_q, idx_d;
  logic [7:0] err_q, err_d;
  logic bcast_q, bcast_d;
  logic [15:0] grp_hi_q, grp_hi_d, grp_lo_q, grp_lo_d;
  logic [15:0] cmd_hi_q, cmd_hi_d, cmd_lo_q, cmd_lo_d;
  logic [31:0] stat_q;
  logic [3:0] tx_q, tx_d;
  logic [15:0] txcrc_q, txcrc_d;
  logic r_valid_q, r_valid_d, r_last_q, r_last_d;
  logic [7:0] r_data_q, r_data_d;

  logic [15:0] count, start, wr_addr, wr_val;
  logic [5:0] pos, bcount;
  logic own_hit, grp_hit;
  logic [7:0] tx_byte;
  logic [3:0] tx_len;

  assign count = {buf_q[4], buf_q[5]};
  assign start = {buf_q[2], buf_q[3]};
  assign bcount = buf_q[6][5:0];
  assign pos = 6'({idx_q, 1'b0}) + 6'(HDR_BYTES);
  assign wr_addr = start + {11'h000, idx_q};
  assign wr_val = {buf_q[pos], buf_q[pos + 6'h01]};
  assign own_hit = buf_q[0] == slave_addr_i;
  // Group only live when the pair holds a parent address
  assign grp_hit = grp_hi_q == 16'h0000 && grp_lo_q != 16'h0000 &&
                   grp_lo_q <= {8'h00, GROUP_MAX} &&
                   buf_q[0] == grp_lo_q[7:0];
  assign tx_len = (err_q != EXC_NONE) ? 4'h5 : 4'h8;

  always_comb begin
    tx_byte = 8'h00;
    if (err_q != EXC_NONE) begin
      case (tx_q)
        4'h0: tx_byte = buf_q[0];
        4'h1: tx_byte = buf_q[1] | FN_EXC_FLAG;
        4'h2: tx_byte = err_q;
        default: tx_byte = 8'h00;
      endcase
    end else if (tx_q < 4'h6) begin
      tx_byte = buf_q[3'(tx_q)];
    end
  end

  // Frame buffer: bytes stored only while collecting
  always_ff @(posedge core_clk_i) begin
    if (st_q == S_RX && link.q_valid && len_q < 6'(BUF_DEPTH)) begin
      buf_q[len_q] <= link.q_data;
    end
  end

  always_comb begin
    st_d = st_q;
    len_d = len_q;
    ovf_d = ovf_q;
    crc_d = crc_q;
    idx_d = idx_q;
    err_d = err_q;
    bcast_d = bcast_q;
    grp_hi_d = grp_hi_q;
    grp_lo_d = grp_lo_q;
    cmd_hi_d = cmd_hi_q;
    cmd_lo_d = cmd_lo_q;
    tx_d = tx_q;
    txcrc_d = txcrc_q;
    r_valid_d = 1'b0;
    r_last_d = 1'b0;
    r_data_d = r_data_q;
    case (st_q)
      S_RX: begin
        if (link.q_valid) begin
          crc_d = crc16_byte(crc_q, link.q_data);
          if (len_q < 6'(BUF_DEPTH)) begin
            len_d = len_q + 6'h01;
          end else begin
            ovf_d = 1'b1;
          end
          if (link.q_last) begin
            st_d = S_CHK;
          end
        end
      end
      S_CHK: begin
        err_d = EXC_NONE;
        idx_d = 5'h00;
        tx_d = 4'h0;
        txcrc_d = CRC_INIT;
        bcast_d = !own_hit;
        // Residue of zero means the trailing check matched
        if (crc_q != 16'h0000 || ovf_q || len_q < MIN_FRAME ||
            !(own_hit || grp_hit)) begin
          st_d = S_RX;
        end else if (buf_q[1] != FN_WRITE_MULTI) begin
          err_d = EXC_BAD_FN;
          st_d = S_TX;
        end else if (count == 16'h0000 ||
                     count > {11'h000, MAX_REGS} ||
                     {8'h00, buf_q[6]} != {count[14:0], 1'b0} ||
                     len_q != FRAME_OVERHEAD + bcount) begin
          err_d = EXC_BAD_DATA;
          st_d = S_TX;
        end else begin
          st_d = S_WR;
        end
      end
      S_WR: begin
        // One register per cycle; errors flagged but never undone
        case (wr_addr)
          REG_GROUP_HI: grp_hi_d = wr_val;
          REG_GROUP_LO: begin
            if (({grp_hi_q, wr_val} == {GROUP_RST, GROUP_RST}) ||
                (grp_hi_q == 16'h0000 && wr_val != 16'h0000 &&
                 wr_val <= {8'h00, GROUP_MAX})) begin
              grp_lo_d = wr_val;
            end else if (err_q == EXC_NONE) begin
              err_d = EXC_BAD_DATA;
            end
          end
          REG_INCMD_HI: cmd_hi_d = wr_val;
          REG_INCMD_LO: cmd_lo_d = wr_val;
          default: begin
            // Status pair and unknown addresses refuse writes
            if (err_q == EXC_NONE) begin
              err_d = EXC_BAD_ADDR;
            end
          end
        endcase
        idx_d = idx_q + 5'h01;
        if ({11'h000, idx_q} == count - 16'h0001) begin
          st_d = S_TX;
        end
      end
      S_TX: begin
        if (bcast_q) begin
          st_d = S_RX;
        end else begin
          r_valid_d = 1'b1;
          tx_d = tx_q + 4'h1;
          if (tx_q < tx_len - 4'h2) begin
            r_data_d = tx_byte;
            txcrc_d = crc16_byte(txcrc_q, tx_byte);
          end else if (tx_q == tx_len - 4'h2) begin
            r_data_d = txcrc_q[7:0];
          end else begin
            r_data_d = txcrc_q[15:8];
            r_last_d = 1'b1;
            st_d = S_RX;
          end
        end
        if (st_d == S_RX) begin
          len_d = 6'h00;
          ovf_d = 1'b0;
          crc_d = CRC_INIT;
        end
      end
      default: st_d = S_RX;
    endcase
    if (st_q == S_CHK && st_d == S_RX) begin
      len_d = 6'h00;
      ovf_d = 1'b0;
      crc_d = CRC_INIT;
    end
  end

  // Command registers are plain flops: volatile by construction
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= S_RX;
      len_q <= 6'h00;
      ovf_q <= 1'b0;
      crc_q <= CRC_INIT;
      idx_q <= 5'h00;
      err_q <= EXC_NONE;
      bcast_q <= 1'b0;
      grp_hi_q <= GROUP_RST;
      grp_lo_q <= GROUP_RST;
      cmd_hi_q <= INCMD_RST;
      cmd_lo_q <= INCMD_RST;
      stat_q <= 32'h0000_0000;
      tx_q <= 4'h0;
      txcrc_q <= CRC_INIT;
      r_valid_q <= 1'b0;
      r_last_q <= 1'b0;
      r_data_q <= 8'h00;
    end else begin
      st_q <= st_d;
      len_q <= len_d;
      ovf_q <= ovf_d;
      crc_q <= crc_d;
      idx_q <= idx_d;
      err_q <= err_d;
      bcast_q <= bcast_d;
      grp_hi_q <= grp_hi_d;
      grp_lo_q <= grp_lo_d;
      cmd_hi_q <= cmd_hi_d;
      cmd_lo_q <= cmd_lo_d;
      stat_q <= drv_status_i;
      tx_q <= tx_d;
      txcrc_q <= txcrc_d;
      r_valid_q <= r_valid_d;
      r_last_q <= r_last_d;
      r_data_q <= r_data_d;
    end
  end

  assign link.r_valid = r_valid_q;
  assign link.r_data = r_data_q;
  assign link.r_last = r_last_q;
  assign drv_cmd_o = {cmd_hi_q, cmd_lo_q};
  assign group_addr_o = {grp_hi_q, grp_lo_q};
  assign drv_status_o = stat_q;
endmodule
`default_nettype wire

// file: design/modbus_master_end.sv
// Master end: builds write-multiple queries from Avalon-MM registers.
// Assumes software fills data words, then writes the control word.
`timescale 1ns/1ps
`default_nettype none
module modbus_master_end (
  input wire logic core_clk_i,
  input wire logic rst_i,
  modbus_link_if.host link,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  import modbus_mw_pkg::*;

  host_state_t st_q, st_d;
  logic [15:0] data_q [0:15];
  logic [7:0] tgt_q, tgt_d;
  logic [15:0] start_q, start_d;
  logic [4:0] cnt_q, cnt_d;
  logic busy_q, busy_d, done_q, done_d, exc_q, exc_d;
  logic crcerr_q, crcerr_d, tmo_q, tmo_d;
  logic [7:0] code_q, code_d, rfn_q, rfn_d;
  logic [5:0] pos_q, pos_d;
  logic [15:0] crc_q, crc_d;
  logic [10:0] wait_q, wait_d;
  logic q_valid_q, q_valid_d, q_last_q, q_last_d;
  logic [7:0] q_data_q, q_data_d;
  logic wr_q, wr_d, wreq_q, wreq_d;
  logic [31:0] rdata_q, rdata_d;

  logic take, wr_take;
  logic [5:0] qlen, k;
  logic [7:0] qbyte;

  // Answer on the second edge of each request
  assign take = (avs_read_i || avs_write_i) && !wr_q;
  // Writes land only on the edge that shows waitrequest low
  assign wr_take = avs_write_i && wr_q;
  assign qlen = FRAME_OVERHEAD + 6'({cnt_q, 1'b0});
  assign k = pos_q - 6'(HDR_BYTES);

  always_comb begin
    case (pos_q)
      6'h00: qbyte = tgt_q;
      6'h01: qbyte = FN_WRITE_MULTI;
      6'h02: qbyte = start_q[15:8];
      6'h03: qbyte = start_q[7:0];
      6'h04: qbyte = 8'h00;
      6'h05: qbyte = {3'h0, cnt_q};
      6'h06: qbyte = {2'h0, cnt_q, 1'b0};
      default: qbyte = k[0] ? data_q[k[4:1]][7:0] : data_q[k[4:1]][15:8];
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (wr_take && avs_address_i >= HREG_DATA) begin
      data_q[avs_address_i[5:2]] <= avs_writedata_i[15:0];
    end
  end

  always_comb begin
    st_d = st_q;
    tgt_d = tgt_q;
    start_d = start_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = done_q;
    exc_d = exc_q;
    crcerr_d = crcerr_q;
    tmo_d = tmo_q;
    code_d = code_q;
    rfn_d = rfn_q;
    pos_d = pos_q;
    crc_d = crc_q;
    wait_d = wait_q;
    q_valid_d = 1'b0;
    q_last_d = 1'b0;
    q_data_d = q_data_q;
    wr_d = take;
    wreq_d = !take;
    rdata_d = rdata_q;
    if (take && avs_read_i) begin
      case (avs_address_i)
        HREG_CTRL: rdata_d = {16'h0000, tgt_q, 8'h00};
        HREG_START: rdata_d = {16'h0000, start_q};
        HREG_COUNT: rdata_d = {27'h0, cnt_q};
        HREG_STATUS: rdata_d = {16'h0000, code_q, 3'h0, tmo_q, crcerr_q,
                                exc_q, done_q, busy_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (wr_take && !busy_q) begin
      case (avs_address_i)
        HREG_START: start_d = avs_writedata_i[15:0];
        HREG_COUNT: begin
          // Clamp so a query never names more than sixteen
          cnt_d = (avs_writedata_i[15:0] > {11'h000, MAX_REGS}) ?
                  MAX_REGS : avs_writedata_i[4:0];
        end
        HREG_CTRL: begin
          if (avs_writedata_i[0] && cnt_q != 5'h00) begin
            tgt_d = avs_writedata_i[15:8];
            busy_d = 1'b1;
            done_d = 1'b0;
            exc_d = 1'b0;
            crcerr_d = 1'b0;
            tmo_d = 1'b0;
            code_d = EXC_NONE;
            pos_d = 6'h00;
            crc_d = CRC_INIT;
            st_d = H_SEND;
          end
        end
        default: ;
      endcase
    end
    case (st_q)
      H_IDLE: ;
      H_SEND: begin
        q_valid_d = 1'b1;
        pos_d = pos_q + 6'h01;
        if (pos_q < qlen - 6'h02) begin
          q_data_d = qbyte;
          crc_d = crc16_byte(crc_q, qbyte);
        end else if (pos_q == qlen - 6'h02) begin
          q_data_d = crc_q[7:0];
        end else begin
          q_data_d = crc_q[15:8];
          q_last_d = 1'b1;
          pos_d = 6'h00;
          crc_d = CRC_INIT;
          wait_d = 11'h000;
          st_d = H_WAIT;
        end
      end
      H_WAIT: begin
        wait_d = wait_q + 11'h001;
        if (link.r_valid) begin
          crc_d = crc16_byte(crc_q, link.r_data);
          pos_d = pos_q + 6'h01;
          if (pos_q == 6'h01) begin
            rfn_d = link.r_data;
          end
          if (pos_q == 6'h02 && rfn_q[7]) begin
            code_d = link.r_data;
          end
          if (link.r_last) begin
            crcerr_d = crc_d != 16'h0000;
            exc_d = rfn_q[7];
            done_d = 1'b1;
            busy_d = 1'b0;
            st_d = H_IDLE;
          end
        end else if (wait_q == RESP_WAIT_CYC) begin
          // Group queries get no answer and end here
          tmo_d = 1'b1;
          done_d = 1'b1;
          busy_d = 1'b0;
          st_d = H_IDLE;
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= H_IDLE;
      tgt_q <= 8'h00;
      start_q <= 16'h0000;
      cnt_q <= 5'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      exc_q <= 1'b0;
      crcerr_q <= 1'b0;
      tmo_q <= 1'b0;
      code_q <= EXC_NONE;
      rfn_q <= 8'h00;
      pos_q <= 6'h00;
      crc_q <= CRC_INIT;
      wait_q <= 11'h000;
      q_valid_q <= 1'b0;
      q_last_q <= 1'b0;
      q_data_q <= 8'h00;
      wr_q <= 1'b0;
      wreq_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      tgt_q <= tgt_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
      exc_q <= exc_d;
      crcerr_q <= crcerr_d;
      tmo_q <= tmo_d;
      code_q <= code_d;
      rfn_q <= rfn_d;
      pos_q <= pos_d;
      crc_q <= crc_d;
      wait_q <= wait_d;
      q_valid_q <= q_valid_d;
      q_last_q <= q_last_d;
      q_data_q <= q_data_d;
      wr_q <= wr_d;
      wreq_q <= wreq_d;
      rdata_q <= rdata_d;
    end
  end

  assign link.q_valid = q_valid_q;
  assign link.q_data = q_data_q;
  assign link.q_last = q_last_q;
  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wreq_q;
endmodule
`default_nettype wire

// file: testbench/modbus_link_sva.sv
// Protocol checker for the query/response byte link between both ends.
// Assumes both ends share core_clk_i and an async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module modbus_link_sva (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic q_valid,
  input wire logic [7:0] q_data,
  input wire logic q_last,
  input wire logic r_valid,
  input wire logic [7:0] r_data,
  input wire logic r_last
);
  // Own copy of the frame check, so a shared slip cannot hide itself
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ 16'hA001) : (x >> 1);
    end
    return x;
  endfunction

  logic [5:0] q_idx_q, q_idx_d;
  logic [15:0] q_crc_q, q_crc_d, q_res;
  logic [7:0] qh_q [7];
  logic [7:0] qh_d [7];
  logic [3:0] r_idx_q, r_idx_d;
  logic [15:0] r_crc_q, r_crc_d, r_res;
  logic r_exc_q, r_exc_d;

  always_comb begin
    q_res = crc_step(q_crc_q, q_data);
    r_res = crc_step(r_crc_q, r_data);
    q_idx_d = q_idx_q;
    q_crc_d = q_crc_q;
    qh_d = qh_q;
    r_idx_d = r_idx_q;
    r_crc_d = r_crc_q;
    r_exc_d = r_exc_q;
    if (q_valid) begin
      if (q_idx_q < 6'h07) begin
        qh_d[q_idx_q[2:0]] = q_data;
      end
      q_idx_d = q_last ? 6'h00 : q_idx_q + 6'h01;
      q_crc_d = q_last ? 16'hFFFF : q_res;
    end
    if (r_valid) begin
      if (r_idx_q == 4'h1) begin
        r_exc_d = r_data[7];
      end
      r_idx_d = r_last ? 4'h0 : r_idx_q + 4'h1;
      r_crc_d = r_last ? 16'hFFFF : r_res;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_idx_q <= 6'h00;
      q_crc_q <= 16'hFFFF;
      qh_q <= '{default: 8'h00};
      r_idx_q <= 4'h0;
      r_crc_q <= 16'hFFFF;
      r_exc_q <= 1'b0;
    end else begin
      q_idx_q <= q_idx_d;
      q_crc_q <= q_crc_d;
      qh_q <= qh_d;
      r_idx_q <= r_idx_d;
      r_crc_q <= r_crc_d;
      r_exc_q <= r_exc_d;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_q_fn;
    q_valid && q_idx_q == 6'h01 |-> q_data == 8'h10;
  endproperty
  a_q_fn: assert property (p_q_fn) else $error("query function byte wrong");
  property p_q_count;
    q_valid && q_idx_q == 6'h06 |-> qh_q[4] == 8'h00 && qh_q[5] <= 8'h10;
  endproperty
  a_q_count: assert property (p_q_count) else $error("query count too big");
  property p_q_bytes;
    q_valid && q_idx_q == 6'h06 |-> q_data == {qh_q[5][6:0], 1'b0};
  endproperty
  a_q_bytes: assert property (p_q_bytes) else $error("byte count wrong");
  property p_q_len;
    q_valid && q_last |-> q_idx_q == 6'(qh_q[6]) + 6'h08;
  endproperty
  a_q_len: assert property (p_q_len) else $error("query length wrong");
  property p_q_crc;
    q_valid && q_last |-> q_res == 16'h0000;
  endproperty
  a_q_crc: assert property (p_q_crc) else $error("query check bad");
  property p_r_crc;
    r_valid && r_last |-> r_res == 16'h0000;
  endproperty
  a_r_crc: assert property (p_r_crc) else $error("response check bad");
  property p_r_gap;
    q_valid && q_last |=> !r_valid;
  endproperty
  a_r_gap: assert property (p_r_gap) else $error("response too early");
  property p_r_burst;
    r_valid && !r_last |=> r_valid;
  endproperty
  a_r_burst: assert property (p_r_burst) else $error("response gap");
  property p_r_len;
    r_valid && r_last |-> (r_idx_q == 4'h7 && !r_exc_q) ||
      (r_idx_q == 4'h4 && r_exc_q);
  endproperty
  a_r_len: assert property (p_r_len) else $error("response length wrong");
  property p_r_echo;
    r_valid && (r_idx_q == 4'h0 || (r_idx_q > 4'h1 && r_idx_q < 4'h6 &&
      !r_exc_q)) |-> r_data == qh_q[r_idx_q[2:0]];
  endproperty
  a_r_echo: assert property (p_r_echo) else $error("echo byte wrong");
  property p_r_fn;
    r_valid && r_idx_q == 4'h1 |-> r_data == qh_q[1] ||
      r_data == (qh_q[1] | 8'h80);
  endproperty
  a_r_fn: assert property (p_r_fn) else $error("response function wrong");

  c_success: cover property (r_valid && r_last && !r_exc_q);
  c_exc: cover property (r_valid && r_last && r_exc_q);
  c_other: cover property (q_valid && q_idx_q == 6'h00 && q_data != 8'h04);
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Top testbench: master end and slave end joined by the byte link.
// Assumes software drives the master end over Avalon-MM only.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import modbus_mw_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o, drv_cmd_o, group_addr_o, drv_status_o;
  logic avs_waitrequest_o;
  logic [31:0] drv_status_i = 32'h0;
  logic [31:0] st;
  int n_mismatch = 0;
  int total_checks = 0;

  always #5 core_clk_i = ~core_clk_i;

  modbus_link_if link_if ();
  modbus_master_end modbus_master_end_inst (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .link(link_if.host), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o));
  modbus_slave_end modbus_slave_end_inst (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .link(link_if.device), .slave_addr_i(8'h04),
    .drv_status_i(drv_status_i), .drv_cmd_o(drv_cmd_o),
    .group_addr_o(group_addr_o), .drv_status_o(drv_status_o));
  modbus_link_sva modbus_link_sva_inst (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .q_valid(link_if.q_valid), .q_data(link_if.q_data),
    .q_last(link_if.q_last), .r_valid(link_if.r_valid),
    .r_data(link_if.r_data), .r_last(link_if.r_last));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic av_access(input logic rd, input logic [7:0] a,
                           input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= rd;
    avs_write_i <= !rd;
    // Only the watchdog ends a wait that never finishes
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic av_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    av_access(1'b0, a, d, dummy);
  endtask

  // One write-multiple query of up to three registers; status returned
  task automatic send(input logic [7:0] tgt, input logic [15:0] start,
                      input logic [4:0] cnt, input logic [15:0] w0,
                      input logic [15:0] w1, input logic [15:0] w2);
    av_write(HREG_DATA, {16'h0, w0});
    av_write(HREG_DATA + 8'h04, {16'h0, w1});
    av_write(HREG_DATA + 8'h08, {16'h0, w2});
    av_write(HREG_START, {16'h0, start});
    av_write(HREG_COUNT, {27'h0, cnt});
    av_write(HREG_CTRL, {16'h0, tgt, 8'h01});
    do begin
      av_access(1'b1, HREG_STATUS, 32'h0, st);
    end while (st[0] !== 1'b0);
  endtask

  initial begin
    repeat (60000) @(posedge core_clk_i);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    check("group reset", group_addr_o, 32'hFFFFFFFF);
    check("cmd reset", drv_cmd_o, 32'h0);
    av_write(HREG_COUNT, 32'h11);
    av_access(1'b1, HREG_COUNT, 32'h0, st);
    check("count clamp", st, 32'h10);
    av_access(1'b1, 8'h20, 32'h0, st);
    check("unmapped read", st, 32'h0);
    $display("test reset and host registers done");

    send(8'h04, REG_INCMD_HI, 5'h02, 16'h1234, 16'h5678, 16'h0);
    check("cmd status", st[4:1], 4'b0001);
    check("cmd pair", drv_cmd_o, 32'h12345678);
    $display("test input command done");

    send(8'h04, REG_GROUP_HI, 5'h02, 16'h0000, 16'h0003, 16'h0);
    check("group set", group_addr_o, 32'h00000003);
    send(8'h04, REG_GROUP_HI, 5'h02, 16'h0000, 16'h0040, 16'h0);
    check("group bad exc", st[2], 1'b1);
    check("group bad code", st[15:8], EXC_BAD_DATA);
    check("group kept", group_addr_o, 32'h00000003);
    $display("test group address done");

    drv_status_i <= 32'hA5A50F0F;
    send(8'h04, REG_OUTST_HI, 5'h02, 16'h1111, 16'h2222, 16'h0);
    check("status exc", st[2], 1'b1);
    check("status code", st[15:8], EXC_BAD_ADDR);
    check("status mirror", drv_status_o, 32'hA5A50F0F);
    $display("test output status done");

    send(8'h04, REG_INCMD_HI, 5'h03, 16'hAAAA, 16'h5555, 16'h0001);
    check("partial code", st[15:8], EXC_BAD_ADDR);
    check("partial kept", drv_cmd_o, 32'hAAAA5555);
    $display("test partial write done");

    send(8'h03, REG_INCMD_HI, 5'h02, 16'h0F0F, 16'hF0F0, 16'h0);
    check("group no reply", st[4], 1'b1);
    check("group applied", drv_cmd_o, 32'h0F0FF0F0);
    send(8'h09, REG_INCMD_HI, 5'h02, 16'h0101, 16'h0202, 16'h0);
    check("foreign no reply", st[4], 1'b1);
    check("foreign ignored", drv_cmd_o, 32'h0F0FF0F0);
    send(8'h04, REG_GROUP_HI, 5'h02, 16'hFFFF, 16'hFFFF, 16'h0);
    check("group off", group_addr_o, 32'hFFFFFFFF);
    $display("test group send done");
    end_of_test();
  end
endmodule
`default_nettype wire
